// ### logic/dacwd_pkg.sv
// Constants, field layouts and types of the DAC write decoder
package dacwd_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int MAIN_W = 10;
    localparam int SUB_W = 8;
    localparam int WORD_W = 16;
    localparam int CNT_W = 4;
    localparam int SYNC_W = 20;

    // ------------------------------------------------------------
    // Serial word layout, sent MSB first
    // ------------------------------------------------------------
    localparam int SER_SUB_BIT = 15;
    localparam int SER_KIND_HI = 14;
    localparam int SER_KIND_LO = 13;
    localparam int SER_CH_HI = 12;
    localparam int SER_CH_LO = 10;
    localparam logic [1:0] SER_KIND_SYS = 2'h0;
    localparam logic [1:0] SER_KIND_DATA = 2'h1;
    localparam logic [1:0] SER_KIND_CHAN = 2'h2;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;

    // ------------------------------------------------------------
    // System control register fields
    // ------------------------------------------------------------
    localparam int SYS_PWR_BIT = 5;
    localparam int SYS_OFFBIN_BIT = 6;
    localparam int SYS_REFL_BIT = 7;
    localparam int SYS_REFH_BIT = 8;

    // ------------------------------------------------------------
    // Channel control register fields
    // ------------------------------------------------------------
    localparam int CH_INTBIAS_BIT = 0;
    localparam int CH_STBY_N_BIT = 4;
    localparam int CH_SUB_BIT = 8;
    localparam int CH_EXTREF_BIT = 9;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [MAIN_W-1:0] SYS_CTRL_RST = 10'h040;
    localparam logic [MAIN_W-1:0] CHAN_CTRL_RST = 10'h000;
    localparam logic [MAIN_W-1:0] MAIN_IN_RST = 10'h200;
    localparam logic [SUB_W-1:0] SUB_IN_RST = 8'h80;
    localparam logic [MAIN_W-1:0] MAIN_OUT_RST = 10'h200;
    localparam logic [SUB_W-1:0] SUB_OUT_RST = 8'h80;
    localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

    // ------------------------------------------------------------
    // Write request carried from decode to the registers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WK_SYS,
        WK_CHAN,
        WK_MAIN,
        WK_SUB
    } dacwd_kind_t;

    typedef struct packed {
        logic valid;
        dacwd_kind_t kind;
        logic [CH_W-1:0] chan;
        logic [MAIN_W-1:0] data;
        logic load_now;
    } dacwd_wreq_t;

endpackage

// ### logic/dacwd_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module dacwd_sync #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] stage1;

    // ------------------------------------------------------------
    // First stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // Idle-high level, so no false strobe edge follows reset
            stage1 <= '1;
            o_sync <= '1;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule

// ### logic/dacwd_top.sv
// Write decoder for a quad/octal 10-bit DAC with per-channel sub DAC
// Operation
// - Parallel system control write with mode 0 ignores channel address.
// - Parallel channel control write with mode 0 goes to addressed channel.
// - Mode 1 parallel writes are DAC data for the addressed channel.
// - System value 020 hex: parallel, twos complement, normal operation.
// - Channel value 011 hex: internal half-supply bias, data to main DAC.
// - Channel control may route parallel data to sub DAC until rewritten.
// - Twos complement main code 200 hex lowest, 1FF hex highest.
// - Offset binary main codes 0..1023, 512 is bias level.
// - Offset binary sub codes 0..255, 10000000 is zero offset.
// - Serial word 0060 hex is system write: offset binary, normal.
// - Serial word 4210 hex sets channel A to external reference.
// - Serial word 23FF hex loads full scale into channel A main DAC.
// - Serial word A3FF hex loads full scale into channel A sub DAC.
// - Serial words travel most significant bit first.
// - Serial data is captured on the falling serial clock edge.
// - Load strobe low at end of write updates output at once.
`timescale 1ns/100ps
module dacwd_top
    import dacwd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_wr_n,
    input wire logic i_mode,
    input wire logic i_ctrl_sel,
    input wire logic [CH_W-1:0] i_channel_address_inputs,
    input wire logic [MAIN_W-1:0] i_data,
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic i_frame_sync_input_n,
    input wire logic i_output_load_strobe_n,
    output logic [MAIN_W-1:0] o_sys_ctrl,
    output logic [NCH-1:0][MAIN_W-1:0] o_chan_ctrl,
    output logic [NCH-1:0][MAIN_W-1:0] o_main_input,
    output logic [NCH-1:0][SUB_W-1:0] o_sub_input,
    output logic [NCH-1:0][MAIN_W-1:0] o_main_code,
    output logic [NCH-1:0][SUB_W-1:0] o_sub_code,
    output logic o_write_done
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic wr_n_s;
    logic mode_s;
    logic ctrl_sel_s;
    logic [CH_W-1:0] addr_s;
    logic [MAIN_W-1:0] data_s;
    logic sclk_s;
    logic sdin_s;
    logic fs_n_s;
    logic ld_n_s;

    assign pins_raw = {i_wr_n, i_mode, i_ctrl_sel,
                       i_channel_address_inputs, i_data, i_sclk,
                       i_sdin, i_frame_sync_input_n,
                       i_output_load_strobe_n};

    dacwd_sync #(
        .W(SYNC_W)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    // Unpack synchronised pins
    assign {wr_n_s, mode_s, ctrl_sel_s, addr_s, data_s, sclk_s,
            sdin_s, fs_n_s, ld_n_s} = pins_s;

    // ------------------------------------------------------------
    // Edge detection on synchronised strobes
    // ------------------------------------------------------------
    logic wr_n_d;
    logic sclk_d;
    logic ld_n_d;
    logic wr_rise;
    logic sclk_fall;
    logic ld_fall;

    // Delayed copies for edge detection
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_n_d <= 1'b1;
            sclk_d <= 1'b1;
            ld_n_d <= 1'b1;
        end else begin
            wr_n_d <= wr_n_s;
            sclk_d <= sclk_s;
            ld_n_d <= ld_n_s;
        end
    end

    // Write ends on the rising strobe; serial bits on the falling clock
    assign wr_rise = ~wr_n_d & wr_n_s;
    assign sclk_fall = sclk_d & ~sclk_s;
    assign ld_fall = ld_n_d & ~ld_n_s;

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] bit_cnt;
    logic ser_bit;
    logic ser_done;
    logic [WORD_W-1:0] ser_word;

    assign ser_bit = sclk_fall & ~fs_n_s;
    assign ser_done = ser_bit & (bit_cnt == LAST_BIT);
    // First bit received lands at the top of the word
    assign ser_word = {shift[WORD_W-2:0], sdin_s};

    // Shift in while framed; a raised frame restarts the count
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift <= SHIFT_RST;
            bit_cnt <= CNT_RST;
        end else if (fs_n_s) begin
            bit_cnt <= CNT_RST;
        end else if (ser_bit) begin
            shift <= ser_word;
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Routing state per channel
    // ------------------------------------------------------------
    logic [MAIN_W-1:0] sys_ctrl;
    logic [NCH-1:0][MAIN_W-1:0] chan_ctrl;
    logic [NCH-1:0] sub_route;
    logic offbin;

    // Each channel keeps its own main/sub choice
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_route
            assign sub_route[g] = chan_ctrl[g][CH_SUB_BIT];
        end
    endgenerate

    // One coding bit steers every channel, main and sub
    assign offbin = sys_ctrl[SYS_OFFBIN_BIT];

    // ------------------------------------------------------------
    // Serial request decode
    // ------------------------------------------------------------
    logic [1:0] ser_kind_f;
    dacwd_kind_t ser_kind;
    dacwd_wreq_t ser_req;

    assign ser_kind_f = ser_word[SER_KIND_HI:SER_KIND_LO];
    // 0060 -> system, 4210 -> channel, 23FF main, A3FF sub
    assign ser_kind = (ser_kind_f == SER_KIND_SYS) ? WK_SYS :
                      (ser_kind_f == SER_KIND_CHAN) ? WK_CHAN :
                      ser_word[SER_SUB_BIT] ? WK_SUB :
                      WK_MAIN;
    assign ser_req = '{valid: ser_done,
                       kind: ser_kind,
                       chan: ser_word[SER_CH_HI:SER_CH_LO],
                       data: ser_word[MAIN_W-1:0],
                       load_now: ~ld_n_s};

    // ------------------------------------------------------------
    // Parallel request decode
    // ------------------------------------------------------------
    dacwd_kind_t par_kind;
    dacwd_wreq_t par_req;

    // Mode 1 is data, routed by the addressed channel's choice
    assign par_kind = mode_s ?
                      (sub_route[addr_s] ? WK_SUB : WK_MAIN) :
                      (ctrl_sel_s ? WK_CHAN : WK_SYS);
    assign par_req = '{valid: wr_rise,
                       kind: par_kind,
                       chan: addr_s,
                       data: data_s,
                       load_now: ~ld_n_s};

    // Serial word wins if both end in one cycle
    dacwd_wreq_t req;
    assign req = ser_req.valid ? ser_req : par_req;

    // ------------------------------------------------------------
    // Code conversion to offset binary form at the outputs
    // ------------------------------------------------------------
    function automatic logic [MAIN_W-1:0] conv_main(
        input logic [MAIN_W-1:0] code,
        input logic is_offbin
    );
        // Twos complement: 200 lowest, 1FF highest after msb flip
        conv_main = is_offbin ? code :
                    {~code[MAIN_W-1], code[MAIN_W-2:0]};
    endfunction

    function automatic logic [SUB_W-1:0] conv_sub(
        input logic [SUB_W-1:0] code,
        input logic is_offbin
    );
        // Offset binary 80 is zero offset; twos complement 00 is zero
        conv_sub = is_offbin ? code :
                   {~code[SUB_W-1], code[SUB_W-2:0]};
    endfunction

    // ------------------------------------------------------------
    // Register writes and output updates
    // ------------------------------------------------------------
    logic [NCH-1:0][MAIN_W-1:0] main_in;
    logic [NCH-1:0][SUB_W-1:0] sub_in;
    logic [NCH-1:0][MAIN_W-1:0] main_out;
    logic [NCH-1:0][SUB_W-1:0] sub_out;

    // Control registers: system write takes no channel address
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sys_ctrl <= SYS_CTRL_RST;
            chan_ctrl <= {NCH{CHAN_CTRL_RST}};
        end else if (req.valid) begin
            case (req.kind)
                WK_SYS: begin
                    sys_ctrl <= req.data;
                end
                WK_CHAN: begin
                    chan_ctrl[req.chan] <= req.data;
                end
                default: begin
                end
            endcase
        end
    end

    // Input data registers for the targeted DAC only
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            main_in <= {NCH{MAIN_IN_RST}};
            sub_in <= {NCH{SUB_IN_RST}};
        end else if (req.valid) begin
            case (req.kind)
                WK_MAIN: begin
                    main_in[req.chan] <= req.data;
                end
                WK_SUB: begin
                    sub_in[req.chan] <= req.data[SUB_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Output registers: strobe edge loads all, low strobe loads now
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            main_out <= {NCH{MAIN_OUT_RST}};
            sub_out <= {NCH{SUB_OUT_RST}};
        end else begin
            if (ld_fall) begin
                for (int c = 0; c < NCH; c++) begin
                    main_out[c] <= conv_main(main_in[c], offbin);
                    sub_out[c] <= conv_sub(sub_in[c], offbin);
                end
            end
            if (req.valid && req.load_now) begin
                case (req.kind)
                    WK_MAIN: begin
                        main_out[req.chan] <=
                            conv_main(req.data, offbin);
                    end
                    WK_SUB: begin
                        sub_out[req.chan] <=
                            conv_sub(req.data[SUB_W-1:0], offbin);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Write-complete pulse
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_write_done <= 1'b0;
        end else begin
            o_write_done <= req.valid;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from registers
    // ------------------------------------------------------------
    assign o_sys_ctrl = sys_ctrl;
    assign o_chan_ctrl = chan_ctrl;
    assign o_main_input = main_in;
    assign o_sub_input = sub_in;
    assign o_main_code = main_out;
    assign o_sub_code = sub_out;

endmodule

// ### verification/dacwd_host.sv
// Host model driving the parallel and serial write pins
`timescale 1ns/100ps
module dacwd_host
    import dacwd_pkg::*;
(
    input wire logic i_mclk,
    output logic o_wr_n,
    output logic o_mode,
    output logic o_ctrl_sel,
    output logic [CH_W-1:0] o_channel_address_inputs,
    output logic [MAIN_W-1:0] o_data,
    output logic o_sclk,
    output logic o_sdin,
    output logic o_frame_sync_input_n,
    output logic o_output_load_strobe_n
);
    // Idle pins at time zero, link clock parked high
    initial begin
        o_wr_n = 1'b1;
        o_mode = 1'b0;
        o_ctrl_sel = 1'b0;
        o_channel_address_inputs = 3'h0;
        o_data = 10'h000;
        o_sclk = 1'b1;
        o_sdin = 1'b0;
        o_frame_sync_input_n = 1'b1;
        o_output_load_strobe_n = 1'b1;
    end
    // Parallel write, fields held around the strobe
    task automatic par_write(input logic m, input logic s,
        input logic [CH_W-1:0] a, input logic [MAIN_W-1:0] d,
        input logic ld);
        @(negedge i_mclk);
        o_mode = m;
        o_ctrl_sel = s;
        o_channel_address_inputs = a;
        o_data = d;
        o_output_load_strobe_n = ld;
        repeat (3) @(negedge i_mclk);
        o_wr_n = 1'b0;
        repeat (4) @(negedge i_mclk);
        o_wr_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        o_data = ~d; // Released bus shows the inverse
        o_output_load_strobe_n = 1'b1;
    endtask
    // Serial word, data changed on the rising link edge
    task automatic ser_write(input logic [WORD_W-1:0] w, input logic ld);
        @(negedge i_mclk);
        o_output_load_strobe_n = ld;
        o_frame_sync_input_n = 1'b0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            repeat (4) @(negedge i_mclk);
            o_sclk = 1'b1;
            o_sdin = w[i];
            repeat (4) @(negedge i_mclk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_mclk);
        o_sclk = 1'b1;
        o_frame_sync_input_n = 1'b1;
        o_sdin = ~o_sdin;
        o_output_load_strobe_n = 1'b1;
    endtask
    // Load strobe pulse for all outputs
    task automatic load_pulse();
        @(negedge i_mclk);
        o_output_load_strobe_n = 1'b0;
        repeat (4) @(negedge i_mclk);
        o_output_load_strobe_n = 1'b1;
    endtask
endmodule

// ### verification/dacwd_props.sv
// Port checker for the DAC write decoder
`timescale 1ns/100ps
module dacwd_props
    import dacwd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_wr_n,
    input wire logic i_mode,
    input wire logic i_ctrl_sel,
    input wire logic [CH_W-1:0] i_channel_address_inputs,
    input wire logic [MAIN_W-1:0] i_data,
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic i_frame_sync_input_n,
    input wire logic i_output_load_strobe_n,
    input wire logic [MAIN_W-1:0] o_sys_ctrl,
    input wire logic [NCH-1:0][MAIN_W-1:0] o_chan_ctrl,
    input wire logic [NCH-1:0][MAIN_W-1:0] o_main_input,
    input wire logic [NCH-1:0][SUB_W-1:0] o_sub_input,
    input wire logic [NCH-1:0][MAIN_W-1:0] o_main_code,
    input wire logic o_write_done
);
    // ----
    // Helpers
    // ----
    logic wr_d, sck_d, p_src, p_mode, p_sel, p_ld;
    logic [CH_W-1:0] p_ch;
    logic [MAIN_W-1:0] p_dat;
    logic [WORD_W-1:0] sreg;
    // Pin edges and decoded fields of the last write
    wire wr_rise = i_wr_n && !wr_d;
    wire sck_fall = sck_d && !i_sclk && !i_frame_sync_input_n;
    wire [1:0] s_kind = sreg[SER_KIND_HI:SER_KIND_LO];
    wire [CH_W-1:0] s_ch = sreg[SER_CH_HI:SER_CH_LO];
    wire [MAIN_W-1:0] s_dat = sreg[MAIN_W-1:0];
    wire p_sub = o_chan_ctrl[p_ch][CH_SUB_BIT];
    wire offb = o_sys_ctrl[SYS_OFFBIN_BIT];
    wire [MAIN_W-1:0] p_code = offb ? p_dat : {~p_dat[9], p_dat[8:0]};
    wire dp = o_write_done && p_src;
    wire ds = o_write_done && !p_src;
    // Edge detectors and source of the last write
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_d <= 1'b1;
            sck_d <= 1'b1;
            p_src <= 1'b0;
        end else begin
            wr_d <= i_wr_n;
            sck_d <= i_sclk;
            p_src <= wr_rise ? 1'b1 : (sck_fall ? 1'b0 : p_src);
        end
    end
    // Capture of parallel fields and the serial word
    always_ff @(posedge i_mclk) begin
        if (wr_rise) begin
            p_mode <= i_mode;
            p_sel <= i_ctrl_sel;
            p_ch <= i_channel_address_inputs;
            p_dat <= i_data;
            p_ld <= i_output_load_strobe_n;
        end
        if (sck_fall) begin
            sreg <= {sreg[WORD_W-2:0], i_sdin};
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    a_sys_par_write: assert property (
        dp && !p_mode && !p_sel |-> o_sys_ctrl == p_dat)
        else $error("parallel system write lost");
    a_chan_par_write: assert property (
        dp && !p_mode && p_sel |-> o_chan_ctrl[p_ch] == p_dat)
        else $error("parallel channel write misplaced");
    a_main_data_write: assert property (
        dp && p_mode && !p_sub |-> o_main_input[p_ch] == p_dat)
        else $error("main data write misplaced");
    a_sub_data_write: assert property (
        dp && p_mode && p_sub |-> o_sub_input[p_ch] == p_dat[7:0])
        else $error("sub data write misplaced");
    a_sync_load_code: assert property (
        dp && p_mode && !p_sub && !p_ld |-> o_main_code[p_ch] == p_code)
        else $error("synchronous update wrong");
    a_ser_sys_word: assert property (
        ds && s_kind == SER_KIND_SYS |-> o_sys_ctrl == s_dat)
        else $error("serial system word wrong");
    a_ser_chan_word: assert property (
        ds && s_kind == SER_KIND_CHAN |-> o_chan_ctrl[s_ch] == s_dat)
        else $error("serial channel word wrong");
    a_ser_main_word: assert property (
        ds && s_kind == SER_KIND_DATA && !sreg[SER_SUB_BIT]
        |-> o_main_input[s_ch] == s_dat)
        else $error("serial main word wrong");
    a_done_one_cycle: assert property (
        o_write_done |=> !o_write_done)
        else $error("write done longer than one cycle");
    a_done_after_wr: assert property (
        $rose(i_wr_n) |-> ##[2:6] o_write_done)
        else $error("no write done after strobe");
    c_sub_route: cover property (dp && p_mode && p_sub);
    c_ser_chan: cover property (ds && s_kind == SER_KIND_CHAN);
    c_sync_load: cover property (dp && !p_ld);
endmodule
bind dacwd_top dacwd_props i_props (.*);

// ### verification/dacwd_top_tb.sv
// Self-checking bench for the DAC write decoder
`timescale 1ns/100ps
module dacwd_top_tb;
    import dacwd_pkg::*;
    logic mclk, arst_n, wr_n, mode, sel, sclk, sdin, fs_n, ld_n;
    logic [CH_W-1:0] addr;
    logic [MAIN_W-1:0] data;
    wire [MAIN_W-1:0] sys;
    wire [NCH-1:0][MAIN_W-1:0] chan, m_in, m_code;
    wire [NCH-1:0][SUB_W-1:0] s_in, s_code;
    wire done;
    int n_tests = 0;
    int miscompares = 0;
    dacwd_host i_host (.i_mclk(mclk), .o_wr_n(wr_n), .o_mode(mode),
        .o_ctrl_sel(sel), .o_channel_address_inputs(addr), .o_data(data),
        .o_sclk(sclk), .o_sdin(sdin), .o_frame_sync_input_n(fs_n),
        .o_output_load_strobe_n(ld_n));
    dacwd_top i_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_wr_n(wr_n),
        .i_mode(mode), .i_ctrl_sel(sel), .i_channel_address_inputs(addr),
        .i_data(data), .i_sclk(sclk), .i_sdin(sdin),
        .i_frame_sync_input_n(fs_n), .i_output_load_strobe_n(ld_n),
        .o_sys_ctrl(sys), .o_chan_ctrl(chan), .o_main_input(m_in),
        .o_sub_input(s_in), .o_main_code(m_code), .o_sub_code(s_code),
        .o_write_done(done));
    // Clock and reset
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        arst_n = 1'b0;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
    end
    task automatic check(input logic [MAIN_W-1:0] got,
        input logic [MAIN_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Bounded wait for the completion pulse
    task automatic wait_done();
        for (int k = 0; k < 300 && done !== 1'b1; k++) @(posedge mclk) #1;
        check(done, 1'b1);
    endtask
    task automatic pw(input logic m, input logic s, input logic [2:0] a,
        input logic [MAIN_W-1:0] d, input logic ld);
        fork
            i_host.par_write(m, s, a, d, ld);
            wait_done();
        join
    endtask
    task automatic sw(input logic [WORD_W-1:0] w, input logic ld);
        fork
            i_host.ser_write(w, ld);
            wait_done();
        join
    endtask
    task automatic t_reset();
        check(sys, SYS_CTRL_RST);
        check(chan[0], CHAN_CTRL_RST);
        check(m_in[7], MAIN_IN_RST);
        check(s_in[7], SUB_IN_RST);
        check(m_code[0], MAIN_OUT_RST);
        check(s_code[0], SUB_OUT_RST);
    endtask
    // Serial words, delayed and immediate update
    task automatic t_serial();
        sw(16'h0060, 1'b1);
        check(sys, 10'h060);
        sw(16'h01E0, 1'b1);
        sw(16'h4210, 1'b1);
        check(chan[0], 10'h210);
        sw(16'h23FF, 1'b1);
        check(m_in[0], 10'h3FF);
        check(m_code[0], MAIN_OUT_RST);
        i_host.load_pulse();
        check(m_code[0], 10'h3FF);
        sw(16'hA3FF, 1'b0);
        check(s_in[0], 8'hFF);
        check(s_code[0], 8'hFF);
        check(s_code[1], 8'h80);
    endtask
    // Parallel control writes and twos complement main codes
    task automatic t_par_main();
        pw(1'b0, 1'b0, 3'h5, 10'h020, 1'b1);
        check(sys, 10'h020);
        check(chan[5], 10'h000);
        pw(1'b0, 1'b1, 3'h3, 10'h011, 1'b1);
        check(chan[3], 10'h011);
        check(chan[2], 10'h000);
        pw(1'b1, 1'b0, 3'h3, 10'h200, 1'b0);
        check(m_code[3], 10'h000);
        pw(1'b1, 1'b0, 3'h3, 10'h1FF, 1'b0);
        check(m_code[3], 10'h3FF);
    endtask
    // Sub DAC routing kept per channel
    task automatic t_par_sub();
        pw(1'b0, 1'b1, 3'h3, 10'h111, 1'b1);
        pw(1'b1, 1'b0, 3'h3, 10'h07F, 1'b0);
        check(s_in[3], 8'h7F);
        check(m_in[3], 10'h1FF);
        check(s_code[3], 8'hFF);
        pw(1'b1, 1'b0, 3'h2, 10'h155, 1'b1);
        check(m_in[2], 10'h155);
        check(s_in[2], 8'h80);
    endtask
    // Main sequence
    initial begin
        repeat (9) @(negedge mclk);
        t_reset();
        t_serial();
        t_par_main();
        t_par_sub();
        stop_test();
    end
    // Watchdog
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule
